// file: hw/fsr_pkg.sv
package fsr_pkg;

  localparam int CLK_MHZ   = 10;
  localparam int T_SUS_US  = 100;
  localparam int T_RS_US   = 80;
  localparam int T_DP_US   = 3;
  localparam int T_RES_US  = 3;
  localparam int SUS_CYC   = T_SUS_US * CLK_MHZ;
  localparam int RS_CYC    = T_RS_US * CLK_MHZ;
  localparam int DP_CYC    = T_DP_US * CLK_MHZ;
  localparam int RES_CYC   = T_RES_US * CLK_MHZ;
  localparam int TMR_W     = 11;
  localparam int OP_W      = 8;
  localparam int NIB_W     = 4;
  localparam int CNT_W     = 4;

  localparam logic [OP_W-1:0]
    OP_SUSPEND_A  = 8'h75, OP_SUSPEND_B  = 8'hb0,
    OP_RESUME_A   = 8'h7a, OP_RESUME_B   = 8'h30,
    OP_STATUS_WR  = 8'h01, OP_POWER_DOWN = 8'hb9,
    OP_RELEASE_PD = 8'hab, OP_RESET_ARM  = 8'h66,
    OP_SOFT_RESET = 8'h99,
    OP_RD_NORM    = 8'h03, OP_RD_FAST    = 8'h0b,
    OP_RD_DIO     = 8'hbb, OP_RD_DO      = 8'h3b,
    OP_RD_QIO     = 8'heb, OP_RD_QO      = 8'h6b,
    OP_RD_DTR     = 8'h0d, OP_RD_DDTR    = 8'hbd,
    OP_RD_QDTR    = 8'hed,
    OP_PROG_SER   = 8'h02, OP_PROG_QA    = 8'h32,
    OP_PROG_QB    = 8'h38, OP_WR_ENABLE  = 8'h06,
    OP_SECT_REL   = 8'h26, OP_SECT_GUARD = 8'h24,
    OP_STATUS_RD  = 8'h05, OP_FUNC_RD    = 8'h48,
    OP_ERR_CLR    = 8'h82, OP_ID_JEDEC   = 8'h9f,
    OP_ID_MFG     = 8'h90, OP_ID_QUAD    = 8'haf,
    OP_UNIQUE_RD  = 8'h4b, OP_PTABLE_RD  = 8'h5a,
    OP_NOP        = 8'h00, OP_INFO_RD    = 8'h68,
    OP_BOOT_RD    = 8'h14, OP_RPARAM_A   = 8'hc0,
    OP_RPARAM_B   = 8'h63, OP_EPARAM_SET = 8'h83,
    OP_RPARAM_RD  = 8'h61, OP_EPARAM_RD  = 8'h81;

  typedef enum logic [1:0] {
    PD_ACTIVE,
    PD_ENTERING,
    PD_DOWN,
    PD_RELEASING
  } fsr_pd_type;

endpackage

// file: hw/fsr_link_if.sv
interface fsr_link_if;
  logic [fsr_pkg::OP_W-1:0] opcode;
  logic                     doneTgl;
  logic                     quadMode;
  modport link (output opcode, output doneTgl, input quadMode);
  modport core (input opcode, input doneTgl, output quadMode);
endinterface

// file: hw/fsr_cmd_shift.sv
// opcode shifter on the serial clock; frame state cleared by chip select
module fsr_cmd_shift (
  input  wire logic                      sclk,
  input  wire logic                      csN,
  input  wire logic                      rstN,
  input  wire logic                      si,
  input  wire logic [fsr_pkg::NIB_W-1:0] quadIn,
  fsr_link_if.link                       lnk
);

  typedef struct packed {
    logic [fsr_pkg::CNT_W-1:0] cnt;
    logic [fsr_pkg::OP_W-1:0]  shift;
  } fsr_frame_type;

  typedef struct packed {
    logic                     qS1;
    logic                     qS2;
    logic [fsr_pkg::OP_W-1:0] opcode;
    logic                     tgl;
  } fsr_hold_type;

  fsr_frame_type f_r, f_nxt;
  fsr_hold_type  h_r, h_nxt;
  logic          frameRst;

  assign frameRst    = csN | ~rstN;
  assign lnk.opcode  = h_r.opcode;
  assign lnk.doneTgl = h_r.tgl;

  always_comb begin
    f_nxt = f_r;
    h_nxt = h_r;
    h_nxt.qS1 = lnk.quadMode;
    h_nxt.qS2 = h_r.qS1;
    if (f_r.cnt < 4'h8) begin
      if (h_r.qS2) begin
        // most significant nibble arrives first  [R8] [R19]
        f_nxt.shift = {f_r.shift[3:0], quadIn};
        f_nxt.cnt   = f_r.cnt + 4'h4;
      end else begin
        f_nxt.shift = {f_r.shift[6:0], si};
        f_nxt.cnt   = f_r.cnt + 4'h1;
      end
      if (f_nxt.cnt == 4'h8) begin
        // whole code latched before chip select may end the frame  [R17]
        h_nxt.opcode = f_nxt.shift;
        h_nxt.tgl    = ~h_r.tgl;
      end
    end
  end

  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge sclk or negedge rstN) begin
    if (!rstN) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

endmodule

// file: hw/fsr_suspend_ctl.sv
// What this block does
// [R1] suspend code 75h/B0h interrupts a running page program
// [R2] while program is suspended, status write and all programs are refused
// [R3] the interrupted page must not be read while program is suspended
// [R4] host frames suspend as chip select low, one code cycle, select high
// [R5] suspend sets its flag then stays busy for the settle time
// [R6] write enable latch cleared when program-suspended flag rises
// [R7] resume 7Ah/30h restarts the operation and clears the suspend flag
// [R8] quad code cycle is two nibbles, most significant first
// [R9] host waits resume-to-suspend delay before another erase suspend
// [R10] host polls write-in-progress until zero after resume
// [R11] array reads accepted during either suspend
// [R12] programs, write enable, suspend, sector lock/unlock only in erase suspend
// [R13] status, function, error clear, resume, ids, tables, nop accepted
// [R14] volatile read-parameter set and read accepted during suspend
// [R15] software reset accepted only right after reset-arm
// [R16] power-down code B9h enters low power, ignoring writes
// [R17] power-down engages only if code latched before select rises
// [R18] in power-down only the release code is recognised
// [R19] power-down entry accepted in serial and quad mode
// [R20] after release, normal operation only once the release time passes
// [R21] release ignored while write-in-progress is set
// [R22] program-suspended is function bit 2, erase-suspended bit 3
// [R23] suspend settle 100us, resume to next suspend 80us
// [R24] suspend ignored during a full chip erase
// [R25] codes outside the accepted set are ignored without side effects
module fsr_suspend_ctl (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      sclk,
  input  wire logic                      csN,
  input  wire logic                      si,
  input  wire logic [fsr_pkg::NIB_W-1:0] quadIn,
  input  wire logic                      quadPeripheralMode,
  input  wire logic                      programActive,
  input  wire logic                      eraseActive,
  input  wire logic                      chipEraseActive,
  output wire logic                      programSuspendedFlag,
  output wire logic                      eraseSuspendedFlag,
  output wire logic                      writeInProgressFlag,
  output wire logic                      writeEnableLatchClr,
  output wire logic                      suspendReq,
  output wire logic                      resumeReq,
  output wire logic                      softResetReq,
  output wire logic                      deepPowerDown,
  output wire logic                      cmdValid,
  output wire logic                      cmdAccept,
  output wire logic [fsr_pkg::OP_W-1:0]  cmdOpcode,
  output wire logic                      protectSuspendedPage
);

  if (fsr_pkg::SUS_CYC >= (1 << fsr_pkg::TMR_W) ||
      fsr_pkg::DP_CYC < 1 || fsr_pkg::RES_CYC < 1) begin : g_chk
    $error("timer width cannot hold the timing counts");
  end

  typedef struct packed {
    logic                       csS1;
    logic                       csS2;
    logic                       csS3;
    logic                       tgS1;
    logic                       tgS2;
    logic                       tgS3;
    logic                       pending;
    logic                       opOk;
    logic [fsr_pkg::OP_W-1:0]   opcode;
    logic                       armed;
    logic                       progSus;
    logic                       eraseSus;
    fsr_pkg::fsr_pd_type        pd;
    logic [fsr_pkg::TMR_W-1:0]  settle;
    logic [fsr_pkg::TMR_W-1:0]  rsTmr;
    logic [fsr_pkg::TMR_W-1:0]  pdTmr;
    logic                       write_in_progress_flag;
    logic                       welClr;
    logic                       susReq;
    logic                       rsmReq;
    logic                       srst;
    logic                       valid;
    logic                       accept;
    logic                       dpd;
  } fsr_state_type;

  fsr_state_type s_r, s_nxt;
  logic          rstS1_r;
  logic          rstN_r;
  logic          engineBusy;
  logic          csRise;
  logic          opArrive;
  logic          exec;
  logic          isSusp;
  logic          isResume;

  fsr_link_if lnk ();

  assign lnk.quadMode = quadPeripheralMode;

  fsr_cmd_shift u_shift (
    .sclk   (sclk),
    .csN    (csN),
    .rstN   (rstN_r),
    .si     (si),
    .quadIn (quadIn),
    .lnk    (lnk.link)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstS1_r <= 1'b0;
      rstN_r  <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstN_r  <= rstS1_r;
    end
  end

  function automatic logic inSuspendSet(input logic [7:0] op,
                                        input logic       es,
                                        input logic       armed);
    logic ok;
    ok = 1'b0;
    case (op)
      fsr_pkg::OP_RD_NORM, fsr_pkg::OP_RD_FAST, fsr_pkg::OP_RD_DIO,
      fsr_pkg::OP_RD_DO, fsr_pkg::OP_RD_QIO, fsr_pkg::OP_RD_QO,
      fsr_pkg::OP_RD_DTR, fsr_pkg::OP_RD_DDTR,
      fsr_pkg::OP_RD_QDTR: ok = 1'b1; // [R11]
      fsr_pkg::OP_STATUS_RD, fsr_pkg::OP_FUNC_RD, fsr_pkg::OP_ERR_CLR,
      fsr_pkg::OP_RESUME_A, fsr_pkg::OP_RESUME_B, fsr_pkg::OP_RELEASE_PD,
      fsr_pkg::OP_ID_JEDEC, fsr_pkg::OP_ID_MFG, fsr_pkg::OP_ID_QUAD,
      fsr_pkg::OP_UNIQUE_RD, fsr_pkg::OP_PTABLE_RD, fsr_pkg::OP_NOP,
      fsr_pkg::OP_INFO_RD, fsr_pkg::OP_BOOT_RD,
      fsr_pkg::OP_RESET_ARM: ok = 1'b1; // [R13]
      fsr_pkg::OP_RPARAM_A, fsr_pkg::OP_RPARAM_B, fsr_pkg::OP_EPARAM_SET,
      fsr_pkg::OP_RPARAM_RD, fsr_pkg::OP_EPARAM_RD: ok = 1'b1; // [R14]
      fsr_pkg::OP_SOFT_RESET: ok = armed; // [R15]
      fsr_pkg::OP_PROG_SER, fsr_pkg::OP_PROG_QA, fsr_pkg::OP_PROG_QB,
      fsr_pkg::OP_WR_ENABLE, fsr_pkg::OP_SUSPEND_A, fsr_pkg::OP_SUSPEND_B,
      fsr_pkg::OP_SECT_REL, fsr_pkg::OP_SECT_GUARD: ok = es; // [R12]
      default: ok = 1'b0; // [R2] [R25]
    endcase
    return ok;
  endfunction

  assign engineBusy = programActive | eraseActive | chipEraseActive;
  assign csRise     = s_r.csS2 & ~s_r.csS3;
  assign opArrive   = s_r.tgS2 ^ s_r.tgS3;
  assign exec       = csRise & s_r.pending;
  assign isSusp     = s_r.opcode == fsr_pkg::OP_SUSPEND_A ||
                      s_r.opcode == fsr_pkg::OP_SUSPEND_B;
  assign isResume   = s_r.opcode == fsr_pkg::OP_RESUME_A ||
                      s_r.opcode == fsr_pkg::OP_RESUME_B;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.csS1   = csN;
    s_nxt.csS2   = s_r.csS1;
    s_nxt.csS3   = s_r.csS2;
    s_nxt.tgS1   = lnk.doneTgl;
    s_nxt.tgS2   = s_r.tgS1;
    s_nxt.tgS3   = s_r.tgS2;
    s_nxt.welClr = 1'b0;
    s_nxt.susReq = 1'b0;
    s_nxt.rsmReq = 1'b0;
    s_nxt.srst   = 1'b0;
    s_nxt.valid  = 1'b0;
    s_nxt.accept = 1'b0;
    if (s_r.settle != '0) begin
      s_nxt.settle = s_r.settle - 1'b1;
    end
    if (s_r.rsTmr != '0) begin
      s_nxt.rsTmr = s_r.rsTmr - 1'b1;
    end
    if (s_r.pdTmr != '0) begin
      s_nxt.pdTmr = s_r.pdTmr - 1'b1;
    end
    case (s_r.pd)
      fsr_pkg::PD_ENTERING: begin
        if (s_r.pdTmr == '0) begin
          s_nxt.pd = fsr_pkg::PD_DOWN; // [R16]
        end
      end
      fsr_pkg::PD_RELEASING: begin
        if (s_r.pdTmr == '0) begin
          s_nxt.pd = fsr_pkg::PD_ACTIVE; // [R20]
        end
      end
      default: begin
      end
    endcase

    // decide on the code once the whole byte is in
    if (opArrive) begin
      s_nxt.valid   = 1'b1;
      s_nxt.opcode  = lnk.opcode;
      s_nxt.pending = 1'b1;
      if (s_r.pd == fsr_pkg::PD_DOWN) begin
        s_nxt.accept = lnk.opcode == fsr_pkg::OP_RELEASE_PD &&
                       !engineBusy; // [R18] [R21]
      end else if (s_r.pd != fsr_pkg::PD_ACTIVE || s_r.settle != '0) begin
        s_nxt.accept = 1'b0; // [R5] [R20]
      end else if (s_r.progSus || s_r.eraseSus) begin
        s_nxt.accept = inSuspendSet(lnk.opcode, s_r.eraseSus && !s_r.progSus,
                                    s_r.armed);
      end else if (lnk.opcode == fsr_pkg::OP_SOFT_RESET) begin
        s_nxt.accept = s_r.armed; // [R15]
      end else begin
        s_nxt.accept = 1'b1;
      end
      s_nxt.opOk = s_nxt.accept;
    end

    // state-changing codes take effect when chip select rises
    if (exec) begin
      s_nxt.pending = 1'b0;
      s_nxt.armed   = s_r.opOk && s_r.opcode == fsr_pkg::OP_RESET_ARM;
      if (s_r.opOk) begin
        if (isSusp && s_r.rsTmr == '0) begin // [R23]
          if (programActive && !s_r.progSus) begin
            s_nxt.progSus = 1'b1; // [R1]
            s_nxt.susReq  = 1'b1;
            s_nxt.welClr  = 1'b1; // [R6]
            s_nxt.settle  = fsr_pkg::TMR_W'(fsr_pkg::SUS_CYC); // [R5]
          end else if (eraseActive && !chipEraseActive &&
                       !s_r.eraseSus && !s_r.progSus) begin // [R24]
            s_nxt.eraseSus = 1'b1;
            s_nxt.susReq   = 1'b1;
            s_nxt.welClr   = 1'b1;
            s_nxt.settle   = fsr_pkg::TMR_W'(fsr_pkg::SUS_CYC);
          end
        end else if (isResume) begin
          if (s_r.progSus) begin
            s_nxt.progSus = 1'b0; // [R7]
            s_nxt.rsmReq  = 1'b1;
          end else if (s_r.eraseSus) begin
            s_nxt.eraseSus = 1'b0; // [R7]
            s_nxt.rsmReq   = 1'b1;
            s_nxt.rsTmr    = fsr_pkg::TMR_W'(fsr_pkg::RS_CYC); // [R9]
          end
        end else if (s_r.opcode == fsr_pkg::OP_SOFT_RESET) begin
          s_nxt.srst = 1'b1; // [R15]
        end else if (s_r.opcode == fsr_pkg::OP_POWER_DOWN &&
                     s_r.pd == fsr_pkg::PD_ACTIVE) begin
          s_nxt.pd    = fsr_pkg::PD_ENTERING; // [R16] [R17] [R19]
          s_nxt.pdTmr = fsr_pkg::TMR_W'(fsr_pkg::DP_CYC);
        end else if (s_r.opcode == fsr_pkg::OP_RELEASE_PD &&
                     s_r.pd == fsr_pkg::PD_DOWN && !engineBusy) begin
          s_nxt.pd    = fsr_pkg::PD_RELEASING; // [R20] [R21]
          s_nxt.pdTmr = fsr_pkg::TMR_W'(fsr_pkg::RES_CYC);
        end
      end
    end else if (csRise) begin
      s_nxt.armed = 1'b0;
    end
    s_nxt.write_in_progress_flag = engineBusy || s_nxt.settle != '0; // [R5] [R10]
    s_nxt.dpd = s_nxt.pd == fsr_pkg::PD_DOWN ||
                s_nxt.pd == fsr_pkg::PD_RELEASING;
  end

  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      s_r      <= '0;
      s_r.csS1 <= 1'b1;
      s_r.csS2 <= 1'b1;
      s_r.csS3 <= 1'b1;
      s_r.pd   <= fsr_pkg::PD_ACTIVE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign programSuspendedFlag = s_r.progSus; // [R22]
  assign eraseSuspendedFlag   = s_r.eraseSus; // [R22]
  assign protectSuspendedPage = s_r.progSus; // [R3]
  assign writeInProgressFlag  = s_r.write_in_progress_flag;
  assign writeEnableLatchClr  = s_r.welClr;
  assign suspendReq           = s_r.susReq;
  assign resumeReq            = s_r.rsmReq;
  assign softResetReq         = s_r.srst;
  assign deepPowerDown        = s_r.dpd;
  assign cmdValid             = s_r.valid;
  assign cmdAccept            = s_r.accept;
  assign cmdOpcode            = s_r.opcode;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN_r);

  sequence progSuspendExec;
    exec && s_r.opOk && isSusp && programActive && !s_r.progSus &&
      s_r.rsTmr == '0;
  endsequence

  sequence pdEntryExec;
    exec && s_r.opOk && s_r.opcode == fsr_pkg::OP_POWER_DOWN &&
      s_r.pd == fsr_pkg::PD_ACTIVE;
  endsequence

  a_prog_suspend_set: assert property (progSuspendExec |=> // [R1]
    programSuspendedFlag && suspendReq)
    else $error("program suspend did not set flag");
  a_settle_busy_hold: assert property ($rose(programSuspendedFlag) |-> // [R5]
    writeInProgressFlag [*8])
    else $error("not busy after suspend");
  a_wel_clear_pulse: assert property ($rose(programSuspendedFlag) |-> // [R6]
    writeEnableLatchClr)
    else $error("write enable latch not cleared");
  a_status_write_ref: assert property (cmdValid && // [R2]
    $past(programSuspendedFlag) && cmdOpcode == fsr_pkg::OP_STATUS_WR
    |-> !cmdAccept)
    else $error("status write accepted during program suspend");
  a_resume_clears: assert property (exec && s_r.opOk && isResume && // [R7]
    s_r.progSus |=> !programSuspendedFlag && resumeReq)
    else $error("resume did not clear flag");
  a_pd_only_release: assert property (cmdValid && $past(deepPowerDown) && // [R18]
    cmdOpcode != fsr_pkg::OP_RELEASE_PD |-> !cmdAccept)
    else $error("code accepted in power-down");
  a_pd_entry_time: assert property (pdEntryExec |-> // [R17]
    ##[1:32] deepPowerDown)
    else $error("power-down not entered in time");
  a_release_wip_ign: assert property (exec && // [R21]
    s_r.opcode == fsr_pkg::OP_RELEASE_PD && engineBusy &&
    s_r.pd == fsr_pkg::PD_DOWN
    |=> $stable(s_r.pd))
    else $error("release acted while busy");
  a_chip_erase_hold: assert property (exec && isSusp && chipEraseActive && // [R24]
    !programActive |=> $stable(eraseSuspendedFlag))
    else $error("chip erase was suspended");

endmodule

// file: dv/fsr_host_model.sv
// host controller: frames one opcode per chip select, link clock only in frames
module fsr_host_model;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sclk;
  logic       csN;
  logic       si;
  logic [3:0] quadIn;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    quadIn = 4'h0;
  end

  // e edges: 8 for serial, 2 for quad, fewer for a cut-short frame
  task automatic send(input logic [7:0] op, input int e);
    csN = 1'b0;
    #37;
    for (int i = 0; i < e; i++) begin
      si = op[7-i];
      quadIn = (i == 0) ? op[7:4] : op[3:0];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #400 csN = 1'b1;
    si = ~si;
    quadIn = ~quadIn;
    #600;
  endtask
endmodule

// file: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] OK_BOTH [27] = '{
    8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed,
    8'h05, 8'h48, 8'h82, 8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a,
    8'h00, 8'h68, 8'h14, 8'hc0, 8'h63, 8'h83, 8'h61, 8'h81, 8'h66};
  localparam logic [7:0] ERASE_ONLY [6] = '{
    8'h02, 8'h32, 8'h38, 8'h06, 8'h26, 8'h24};
  localparam logic [7:0] NO_PROG [9] = '{
    8'h01, 8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hb0, 8'h26, 8'h24};

  logic       core_clk;
  logic       nrst;
  logic       quadPeripheralMode;
  logic       programActive;
  logic       eraseActive;
  logic       chipEraseActive;
  logic       programSuspendedFlag;
  logic       eraseSuspendedFlag;
  logic       writeInProgressFlag;
  logic       writeEnableLatchClr;
  logic       suspendReq;
  logic       resumeReq;
  logic       softResetReq;
  logic       deepPowerDown;
  logic       cmdValid;
  logic       cmdAccept;
  logic [7:0] cmdOpcode;
  logic       protectSuspendedPage;
  logic [1:0] got;
  logic [3:0] pul;
  int         failures;
  int         n_compared;

  fsr_host_model host ();

  fsr_suspend_ctl dut (
    .core_clk, .nrst, .sclk(host.sclk), .csN(host.csN), .si(host.si),
    .quadIn(host.quadIn), .quadPeripheralMode, .programActive,
    .eraseActive, .chipEraseActive, .programSuspendedFlag,
    .eraseSuspendedFlag, .writeInProgressFlag, .writeEnableLatchClr,
    .suspendReq, .resumeReq, .softResetReq, .deepPowerDown, .cmdValid,
    .cmdAccept, .cmdOpcode, .protectSuspendedPage
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // sticky capture of arrivals and single-cycle pulses
  always @(posedge core_clk) begin
    if (cmdValid === 1'b1)
      got = {1'b1, cmdAccept};
    pul |= {softResetReq, writeEnableLatchClr, resumeReq, suspendReq};
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // exp: {arrived, accepted}
  task automatic cmd(input logic [7:0] op, input int e,
                     input logic [1:0] exp);
    got = 2'b00;
    pul = 4'h0;
    host.send(op, e);
    check({6'h0, got}, {6'h0, exp});
    if (exp[1])
      check(cmdOpcode, op);
  endtask

  task automatic set_eng(input logic q, input logic p, input logic e,
                         input logic c);
    @(posedge core_clk);
    #1;
    quadPeripheralMode = q;
    programActive = p;
    eraseActive = e;
    chipEraseActive = c;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // settle timer must run close to its full length, bounded wait
  task automatic wait_wip;
    int k;
    k = 0;
    while (writeInProgressFlag !== 1'b0 && k < 1200) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check({7'h0, k > 900 && k < 1200}, 8'h01);
    if (k >= 1200)
      close_out();
  endtask

  initial begin
    failures = 0;
    n_compared = 0;
    nrst = 1'b0;
    quadPeripheralMode = 1'b0;
    programActive = 1'b0;
    eraseActive = 1'b0;
    chipEraseActive = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    wait_cyc(4);
    check({programSuspendedFlag, eraseSuspendedFlag, writeInProgressFlag,
           deepPowerDown, protectSuspendedPage, 3'h0}, 8'h00);
    // program suspend
    set_eng(1'b0, 1'b1, 1'b0, 1'b0);
    cmd(8'h75, 8, 2'b11);
    check({4'h0, pul}, 8'h05);
    check({5'h0, programSuspendedFlag, protectSuspendedPage,
           writeInProgressFlag}, 8'h07);
    set_eng(1'b0, 1'b0, 1'b0, 1'b0);
    cmd(8'h05, 8, 2'b10);
    wait_wip();
    cmd(8'h99, 8, 2'b10);
    foreach (OK_BOTH[i]) cmd(OK_BOTH[i], 8, 2'b11);
    foreach (NO_PROG[i]) cmd(NO_PROG[i], 8, 2'b10);
    check({pul, 2'h0, programSuspendedFlag, eraseSuspendedFlag},
          8'h02);
    cmd(8'h7a, 8, 2'b11);
    check({pul, 2'h0, programSuspendedFlag, protectSuspendedPage},
          8'h20);
    // chip erase cannot be suspended, erase engine busy as well
    set_eng(1'b0, 1'b0, 1'b1, 1'b1);
    cmd(8'h75, 8, 2'b11);
    check({pul, 3'h0, eraseSuspendedFlag}, 8'h00);
    // erase suspend in quad mode
    set_eng(1'b1, 1'b0, 1'b1, 1'b0);
    host.send(8'h00, 8);
    cmd(8'hb0, 2, 2'b11);
    check({pul, 2'h0, programSuspendedFlag, eraseSuspendedFlag},
          8'h51);
    set_eng(1'b1, 1'b0, 1'b0, 1'b0);
    wait_wip();
    foreach (ERASE_ONLY[i]) cmd(ERASE_ONLY[i], 2, 2'b11);
    cmd(8'h01, 2, 2'b10);
    cmd(8'h30, 2, 2'b11);
    check({pul, 3'h0, eraseSuspendedFlag}, 8'h20);
    set_eng(1'b1, 1'b0, 1'b1, 1'b0);
    cmd(8'h75, 2, 2'b11);
    check({pul, 3'h0, eraseSuspendedFlag}, 8'h00);
    // deep power-down
    set_eng(1'b1, 1'b0, 1'b0, 1'b0);
    cmd(8'hb9, 1, 2'b00);
    wait_cyc(40);
    check({6'h0, writeInProgressFlag, deepPowerDown}, 8'h00);
    cmd(8'hb9, 2, 2'b11);
    wait_cyc(40);
    check({7'h0, deepPowerDown}, 8'h01);
    cmd(8'h05, 2, 2'b10);
    cmd(8'h06, 2, 2'b10);
    set_eng(1'b1, 1'b1, 1'b0, 1'b0);
    cmd(8'hab, 2, 2'b10);
    wait_cyc(40);
    check({7'h0, deepPowerDown}, 8'h01);
    set_eng(1'b1, 1'b0, 1'b0, 1'b0);
    cmd(8'hab, 2, 2'b11);
    check({7'h0, deepPowerDown}, 8'h01);
    wait_cyc(40);
    check({7'h0, deepPowerDown}, 8'h00);
    cmd(8'h05, 2, 2'b11);
    // software reset needs the arm code first
    cmd(8'h99, 2, 2'b10);
    cmd(8'h66, 2, 2'b11);
    cmd(8'h99, 2, 2'b11);
    check({4'h0, pul}, 8'h08);
    close_out();
  end
endmodule
